// >>> hw/pbmc_top.sv
// Power bank mode control: lock-out, charger stages, boost and Type-C DRP
`timescale 1ns/1ps
module pbmc_top
  import pbmc_pkg::*;
#(
  parameter int DEB_CYCLES   = DEB_CYC,
  parameter int DRP_CYCLES   = DRP_CYC,
  parameter int DRP_SRC_CYCLES = DRP_SRC_CYC,
  parameter int TRY_CYCLES   = TRY_SRC_CYC,
  parameter int LIGHT_CYCLES = LIGHT_LOAD_CYC,
  parameter int FLASH_CYCLES = FLASH_CYC,
  parameter int SOFT_CYCLES  = SOFT_START_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        bat_present,
  input  wire logic        bat_low,
  input  wire logic        bat_above_3v,
  input  wire logic        bat_near_target,
  input  wire logic        bat_below_recharge,
  input  wire logic        ichg_below_stop,
  input  wire logic        vin_present,
  input  wire logic        vin_fast,
  input  wire logic        vin_droop,
  input  wire logic        key_press,
  input  wire logic        load_detect,
  input  wire logic        boost_ocp,
  input  wire logic        boost_short,
  input  wire logic        boost_ovp,
  input  wire logic        die_otp,
  input  wire logic        die_hot,
  input  wire logic [2:0]  cc1_cmp,
  input  wire logic [2:0]  cc2_cmp,
  output logic             chg_en,
  output logic [2:0]       ichg_code,
  output logic             pin_limit_18w,
  output logic             out_port_en,
  output logic             boost_en,
  output logic             boost_soft,
  output logic [1:0]       boost_vsel,
  output logic             boost_derate,
  output logic             led_flash,
  output logic             cc1_rp_en,
  output logic             cc1_rd_en,
  output logic             cc2_rp_en,
  output logic             cc2_rd_en,
  output logic [1:0]       rp_level,
  output logic [1:0]       snk_adv,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int NIN = 22;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] deb;
  pbmc_pwr_t      pwr_reg;
  pbmc_chg_t      chg_reg;
  pbmc_tc_t       tc_reg;
  logic [3:0]     ctrl_reg;
  logic           key_prev_reg;
  logic           bat_prev_reg;
  logic           droop_prev_reg;
  logic           fault_reg;
  logic [31:0]    light_cnt_reg;
  logic [31:0]    soft_cnt_reg;
  logic [31:0]    flash_cnt_reg;
  logic [3:0]     flash_halves_reg;
  logic [31:0]    drp_cnt_reg;
  logic [31:0]    settle_cnt_reg;
  logic [2:0]     ilvl_reg;
  logic           role_src_reg;
  logic           aw_got_reg;
  logic           w_got_reg;
  logic [7:0]     awaddr_reg;
  logic [31:0]    wdata_reg;
  logic [3:0]     wstrb_reg;

  assign raw_in = {cc2_cmp, cc1_cmp, die_hot, die_otp, boost_ovp, boost_short, boost_ocp,
                   load_detect, key_press, vin_droop, vin_fast, vin_present,
                   ichg_below_stop, bat_below_recharge, bat_near_target, bat_above_3v,
                   bat_low, bat_present};

  // Pins are asynchronous to clk_sys; one debounce for all keeps area low
  pbmc_sync_deb #(.W(NIN), .CNT(DEB_CYCLES)) u_deb (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .din     (raw_in),
    .dout    (deb)
  );

  logic d_bat, d_low, d_3v, d_tgt, d_rch, d_stop, d_vin, d_fast, d_droop, d_key, d_load;
  logic d_fault, d_hot;
  logic [2:0] d_cc1, d_cc2;
  assign d_bat   = deb[0];
  assign d_low   = deb[1];
  assign d_3v    = deb[2];
  assign d_tgt   = deb[3];
  assign d_rch   = deb[4];
  assign d_stop  = deb[5];
  assign d_vin   = deb[6];
  assign d_fast  = deb[7];
  assign d_droop = deb[8];
  assign d_key   = deb[9];
  assign d_load  = deb[10];
  assign d_fault = |deb[14:11];
  assign d_hot   = deb[15];
  assign d_cc1   = deb[18:16];
  assign d_cc2   = deb[21:19];

  logic key_rise, bat_rise, droop_rise;
  assign key_rise   = d_key & ~key_prev_reg;
  assign bat_rise   = d_bat & ~bat_prev_reg;
  assign droop_rise = d_droop & ~droop_prev_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_prev_reg   <= 1'b0;
      bat_prev_reg   <= 1'b0;
      droop_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      key_prev_reg   <= d_key;
      bat_prev_reg   <= d_bat;
      droop_prev_reg <= d_droop;
    end
  end

  // Power state; reset stands for the first battery connection
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pwr_reg <= PWR_LOCK;
    else if (ce)
    begin
      if (bat_rise)
        pwr_reg <= PWR_LOCK;
      else if (d_vin)
        pwr_reg <= PWR_CHG;
      else
        unique case (pwr_reg)
          PWR_LOCK: pwr_reg <= PWR_LOCK;
          PWR_CHG:  pwr_reg <= d_low ? PWR_LOCK : PWR_IDLE;
          PWR_IDLE:
            if (d_low)
              pwr_reg <= PWR_LOCK;
            else if (key_rise || d_load)
              pwr_reg <= PWR_DIS;
          PWR_DIS:
            if (d_low)
              pwr_reg <= PWR_LOCK;
            else if (light_cnt_reg >= 32'(LIGHT_CYCLES - 1))
              pwr_reg <= PWR_IDLE;
          default: pwr_reg <= PWR_LOCK;
        endcase
    end
  end

  // Light-load timeout returns to standby
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      light_cnt_reg <= '0;
    else if (ce)
    begin
      if (pwr_reg != PWR_DIS || d_load)
        light_cnt_reg <= '0;
      else
        light_cnt_reg <= light_cnt_reg + 32'h1;
    end
  end

  // Four flashes, eight half periods; a running burst is not restarted by the settling pin
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_halves_reg <= FLASH_HALVES;
      flash_cnt_reg    <= '0;
    end
    else if (ce)
    begin
      if ((bat_rise || (pwr_reg == PWR_LOCK && key_rise)) && flash_halves_reg == 4'h0)
      begin
        flash_halves_reg <= FLASH_HALVES;
        flash_cnt_reg    <= '0;
      end
      else if (flash_halves_reg != 4'h0)
      begin
        if (flash_cnt_reg >= 32'(FLASH_CYCLES - 1))
        begin
          flash_cnt_reg    <= '0;
          flash_halves_reg <= flash_halves_reg - 4'h1;
        end
        else
          flash_cnt_reg <= flash_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      led_flash <= 1'b0;
    else if (ce)
      led_flash <= flash_halves_reg[0];
  end

  // Charge stages
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      chg_reg <= CHG_TRK;
    else if (ce)
    begin
      if (pwr_reg != PWR_CHG)
        chg_reg <= d_3v ? CHG_CC : CHG_TRK;
      else
        unique case (chg_reg)
          CHG_TRK:  if (d_3v) chg_reg <= CHG_CC;
          CHG_CC:
            if (!d_3v)
              chg_reg <= CHG_TRK;
            else if (d_tgt)
              chg_reg <= CHG_CV;
          CHG_CV:   if (d_stop && d_tgt) chg_reg <= CHG_DONE;
          CHG_DONE: if (d_rch) chg_reg <= d_3v ? CHG_CC : CHG_TRK;
          default:  chg_reg <= CHG_TRK;
        endcase
    end
  end

  // Adapter sag steps the current level down; a new session starts at the top
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ilvl_reg <= ICHG_MAX;
    else if (ce)
    begin
      if (pwr_reg != PWR_CHG)
        ilvl_reg <= ICHG_MAX;
      else if (droop_rise && ilvl_reg != ICHG_TRICKLE + 3'h1)
        ilvl_reg <= ilvl_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chg_en        <= 1'b0;
      ichg_code     <= ICHG_TRICKLE;
      pin_limit_18w <= 1'b0;
      out_port_en   <= 1'b0;
    end
    else if (ce)
    begin
      chg_en        <= pwr_reg == PWR_CHG && chg_reg != CHG_DONE;
      ichg_code     <= chg_reg == CHG_TRK ? ICHG_TRICKLE : ilvl_reg;
      pin_limit_18w <= d_fast;
      out_port_en   <= pwr_reg == PWR_DIS && !fault_reg;
    end
  end

  // Boost: faults latch off until the discharge session ends
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_reg    <= 1'b0;
      soft_cnt_reg <= '0;
    end
    else if (ce)
    begin
      if (pwr_reg != PWR_DIS)
      begin
        fault_reg    <= 1'b0;
        soft_cnt_reg <= '0;
      end
      else
      begin
        if (d_fault)
          fault_reg <= 1'b1;
        if (soft_cnt_reg < 32'(SOFT_CYCLES))
          soft_cnt_reg <= soft_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boost_en     <= 1'b0;
      boost_soft   <= 1'b0;
      boost_vsel   <= VSEL_5V;
      boost_derate <= 1'b0;
    end
    else if (ce)
    begin
      boost_en     <= pwr_reg == PWR_DIS && !fault_reg && !d_fault;
      boost_soft   <= pwr_reg == PWR_DIS && soft_cnt_reg < 32'(SOFT_CYCLES);
      boost_vsel   <= ctrl_reg[CTRL_VSEL_LSB +: 2];
      boost_derate <= d_hot;
    end
  end

  // Type-C: classify the debounced comparators by the current role
  logic cc1_rd, cc2_rd, cc1_ra, cc2_ra, src_seen, rd_seen, settled;
  assign cc1_rd   = !d_cc1[0] && d_cc1[1];
  assign cc2_rd   = !d_cc2[0] && d_cc2[1];
  assign rd_seen  = cc1_rd || cc2_rd;
  assign cc1_ra   = d_cc1[0];
  assign cc2_ra   = d_cc2[0];
  assign src_seen = !cc1_ra || !cc2_ra;
  // Comparator meaning changes with the role, so stale results are skipped
  assign settled  = settle_cnt_reg >= 32'(2 * DEB_CYCLES + 4);

  logic want_src;
  always_comb
  begin
    unique case (tc_reg)
      TC_UNATT: want_src = drp_cnt_reg < 32'(DRP_SRC_CYCLES);
      TC_TRY:   want_src = 1'b1;
      TC_SRC:   want_src = 1'b1;
      TC_SNK:   want_src = 1'b0;
      default:  want_src = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      role_src_reg   <= 1'b1;
      settle_cnt_reg <= '0;
    end
    else if (ce)
    begin
      role_src_reg <= want_src;
      if (want_src != role_src_reg)
        settle_cnt_reg <= '0;
      else if (!settled)
        settle_cnt_reg <= settle_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      drp_cnt_reg <= '0;
    else if (ce)
    begin
      if (tc_reg != TC_UNATT && tc_reg != TC_TRY)
        drp_cnt_reg <= '0;
      else if (drp_cnt_reg >= 32'(DRP_CYCLES - 1))
        drp_cnt_reg <= '0;
      else
        drp_cnt_reg <= drp_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tc_reg <= TC_UNATT;
    else if (ce && settled && want_src == role_src_reg)
    begin
      unique case (tc_reg)
        TC_UNATT:
          if (role_src_reg && rd_seen)
            tc_reg <= TC_SRC;
          else if (!role_src_reg && src_seen)
            tc_reg <= TC_TRY;
        TC_TRY:
          if (rd_seen)
            tc_reg <= TC_SRC;
          else if (drp_cnt_reg >= 32'(TRY_CYCLES - 1) || drp_cnt_reg == '0)
            tc_reg <= TC_SNK;
        TC_SRC:   if (!rd_seen) tc_reg <= TC_UNATT;
        TC_SNK:   if (!src_seen) tc_reg <= TC_UNATT;
        default:  tc_reg <= TC_UNATT;
      endcase
    end
  end

  // Sink advertisement from the connected pin, the one above vRa
  logic [2:0] adv_pin;
  assign adv_pin = !cc1_ra ? d_cc1 : d_cc2;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cc1_rp_en <= 1'b0;
      cc1_rd_en <= 1'b0;
      cc2_rp_en <= 1'b0;
      cc2_rd_en <= 1'b0;
      rp_level  <= ADV_DEF;
      snk_adv   <= ADV_DEF;
    end
    else if (ce)
    begin
      cc1_rp_en <= role_src_reg;
      cc2_rp_en <= role_src_reg;
      cc1_rd_en <= !role_src_reg;
      cc2_rd_en <= !role_src_reg;
      rp_level  <= ctrl_reg[CTRL_RP_LSB +: 2] > ADV_3A0 ? ADV_3A0 : ctrl_reg[CTRL_RP_LSB +: 2];
      if (tc_reg != TC_SNK)
        snk_adv <= ADV_DEF;
      else if (adv_pin[1])
        snk_adv <= ADV_DEF;
      else if (adv_pin[2])
        snk_adv <= ADV_1A5;
      else
        snk_adv <= ADV_3A0;
    end
  end

  // AXI4-Lite slave: address and data may arrive in either order
  logic wr_go;
  assign wr_go = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
      ctrl_reg      <= CTRL_RST;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_reg    <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= awaddr_reg == ADDR_CTRL ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_reg == ADDR_CTRL && wstrb_reg[0])
          ctrl_reg <= wdata_reg[3:0];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_got_reg    <= 1'b0;
        w_got_reg     <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        s_axi_rdata   <= '0;
        unique case (s_axi_araddr[7:0])
          ADDR_CTRL:   s_axi_rdata[3:0] <= ctrl_reg;
          ADDR_STATUS:
          begin
            s_axi_rdata[STAT_PWR_LSB +: 4]  <= pwr_reg;
            s_axi_rdata[STAT_CHG_LSB +: 4]  <= chg_reg;
            s_axi_rdata[STAT_FAULT_BIT]     <= fault_reg;
            s_axi_rdata[STAT_LIMIT_BIT]     <= d_fast;
            s_axi_rdata[STAT_ICHG_LSB +: 3] <= ichg_code;
          end
          ADDR_CC:
          begin
            s_axi_rdata[CC_TC_LSB +: 4]  <= tc_reg;
            s_axi_rdata[CC_ADV_LSB +: 2] <= snk_adv;
            s_axi_rdata[CC_RP_LSB +: 2]  <= rp_level;
          end
          default:     s_axi_rresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : pbmc_top

// >>> hw/pbmc_pkg.sv
// Shared constants and types of the power bank mode controller
package pbmc_pkg;
  localparam int CLK_HZ          = 50_000_000;
  localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS      = CLK_HZ / 1_000;
  // Timing in printed units, then cycle counts derived from them
  localparam int DEB_US          = 1000;
  localparam int DEB_CYC         = DEB_US * CYC_PER_US;
  localparam int DRP_PERIOD_MS   = 75;
  localparam int DRP_CYC         = DRP_PERIOD_MS * CYC_PER_MS;
  localparam int DRP_SRC_PCT     = 50;
  localparam int DRP_SRC_CYC     = (DRP_CYC / 100) * DRP_SRC_PCT;
  localparam int TRY_SRC_MS      = 100;
  localparam int TRY_SRC_CYC     = TRY_SRC_MS * CYC_PER_MS;
  localparam int LIGHT_LOAD_MS   = 32000;
  localparam int LIGHT_LOAD_CYC  = LIGHT_LOAD_MS * CYC_PER_MS;
  localparam int FLASH_MS        = 250;
  localparam int FLASH_CYC       = FLASH_MS * CYC_PER_MS;
  localparam int SOFT_START_US   = 2000;
  localparam int SOFT_START_CYC  = SOFT_START_US * CYC_PER_US;
  localparam logic [3:0] FLASH_HALVES = 4'h8;
  // Register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CC     = 8'h08;
  localparam int CTRL_VSEL_LSB   = 0;
  localparam int CTRL_RP_LSB     = 2;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int STAT_PWR_LSB    = 0;
  localparam int STAT_CHG_LSB    = 4;
  localparam int STAT_FAULT_BIT  = 8;
  localparam int STAT_LIMIT_BIT  = 9;
  localparam int STAT_ICHG_LSB   = 12;
  localparam int CC_TC_LSB       = 0;
  localparam int CC_ADV_LSB      = 4;
  localparam int CC_RP_LSB       = 6;
  // Charge current codes: trickle stays under 250 mA, top code is 5.0 A
  localparam logic [2:0] ICHG_TRICKLE = 3'h0;
  localparam logic [2:0] ICHG_MAX     = 3'h7;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic [3:0] {
    PWR_LOCK = 4'b0001, PWR_IDLE = 4'b0010, PWR_CHG = 4'b0100, PWR_DIS = 4'b1000
  } pbmc_pwr_t;
  typedef enum logic [3:0] {
    CHG_TRK = 4'b0001, CHG_CC = 4'b0010, CHG_CV = 4'b0100, CHG_DONE = 4'b1000
  } pbmc_chg_t;
  typedef enum logic [3:0] {
    TC_UNATT = 4'b0001, TC_TRY = 4'b0010, TC_SRC = 4'b0100, TC_SNK = 4'b1000
  } pbmc_tc_t;
  // Boost pairs: 5V/3.1A, 7V/2.4A, 9V/2.0A, 12V/1.5A
  typedef enum logic [1:0] {
    VSEL_5V = 2'h0, VSEL_7V = 2'h1, VSEL_9V = 2'h2, VSEL_12V = 2'h3
  } pbmc_vsel_t;
  // Current advertisement levels on CC
  typedef enum logic [1:0] {
    ADV_DEF = 2'h0, ADV_1A5 = 2'h1, ADV_3A0 = 2'h2
  } pbmc_adv_t;
endpackage : pbmc_pkg

// >>> hw/pbmc_sync_deb.sv
// Three-stage synchroniser with a stability debounce on a vector
`timescale 1ns/1ps
module pbmc_sync_deb
  import pbmc_pkg::*;
#(
  parameter int W   = 1,
  parameter int CNT = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] dout_reg;
  logic [31:0]  cnt_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else if (ce)
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once stages two and three agree, held CNT cycles
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= '0;
      dout_reg <= '0;
    end
    else if (ce)
    begin
      if (s2_reg != s3_reg || s3_reg == dout_reg)
        cnt_reg <= '0;
      else if (cnt_reg >= 32'(CNT - 1))
      begin
        cnt_reg  <= '0;
        dout_reg <= s3_reg;
      end
      else
        cnt_reg <= cnt_reg + 32'h1;
    end
  end

  assign dout = dout_reg;
endmodule : pbmc_sync_deb

// >>> verification/pbmc_props.sv
// Concurrent checks on the mode controller top ports
`timescale 1ns/1ps
module pbmc_props
  import pbmc_pkg::*;
#(
  parameter int DEB_CYCLES = 4,
  parameter int DRP_CYCLES = 200
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       bat_above_3v,
  input wire logic       vin_present,
  input wire logic       vin_fast,
  input wire logic       boost_ocp,
  input wire logic [2:0] cc1_cmp,
  input wire logic       chg_en,
  input wire logic [2:0] ichg_code,
  input wire logic       pin_limit_18w,
  input wire logic       out_port_en,
  input wire logic       boost_en,
  input wire logic       boost_soft,
  input wire logic       cc1_rp_en
);
  // Longest source phase, 70 percent of the toggle period
  localparam int RP_MAX = DRP_CYCLES * 70 / 100;
  int   low_cnt, vin_cnt, rp_run;
  logic left_lock;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n)
    low_cnt <= (!rst_n || bat_above_3v) ? 0 : low_cnt + 1;
  always_ff @(posedge clk_sys or negedge rst_n)
    vin_cnt <= (!rst_n || !vin_present) ? 0 : vin_cnt + 1;
  // A seen sink ends toggling, so the run restarts there
  always_ff @(posedge clk_sys or negedge rst_n)
    rp_run <= (!rst_n || !cc1_rp_en || cc1_cmp != 3'h0) ? 0 : rp_run + 1;
  always_ff @(posedge clk_sys or negedge rst_n)
    left_lock <= rst_n && (left_lock || chg_en);
  sequence s_fault; boost_ocp [*8]; endsequence
  sequence s_slow; !vin_fast [*8]; endsequence
  a_out_closed: assert property (chg_en |-> !out_port_en && !boost_en)
    else $error("output open while charging");
  a_trickle_cap: assert property (chg_en && low_cnt > 16 |-> ichg_code == ICHG_TRICKLE)
    else $error("charge current above trickle");
  a_charge_deb: assert property ($rose(chg_en) |-> vin_cnt >= DEB_CYCLES)
    else $error("charge began without settled input");
  a_lock_quiet: assert property (!left_lock |-> !boost_en && !out_port_en)
    else $error("output woke in lock-out");
  a_src_share: assert property (rp_run <= RP_MAX)
    else $error("source phase too long");
  a_fault_stop: assert property (s_fault ##1 s_fault |-> ##[0:2] !boost_en)
    else $error("boost kept running on fault");
  a_soft_first: assert property ($rose(boost_en) |-> ##[0:1] boost_soft)
    else $error("boost started without soft start");
  a_fast_limit: assert property (s_slow ##1 s_slow |-> !pin_limit_18w)
    else $error("high input limit without fast input");
endmodule : pbmc_props

// >>> verification/pbmc_partner.sv
// Battery and cable partner seen through the comparators
`timescale 1ns/1ps
module pbmc_partner (
  input  wire logic [12:0] bat_mv,
  input  wire logic        snk_att,
  input  wire logic        cc1_rp_en,
  input  wire logic        cc2_rp_en,
  output logic             bat_above_3v,
  output logic             bat_near_target,
  output logic             bat_below_recharge,
  output logic [2:0]       cc1_cmp,
  output logic [2:0]       cc2_cmp
);
  // Thresholds 3000, 4150 and 4100 mV
  assign bat_above_3v       = bat_mv > 13'h0bb8;
  assign bat_near_target    = bat_mv >= 13'h1036;
  assign bat_below_recharge = bat_mv < 13'h1004;
  // Sink Rd sits between source thresholds; without pull-up CC rests at 0 V
  assign cc1_cmp = cc1_rp_en ? {1'b0, snk_att, 1'b0} : 3'h7;
  assign cc2_cmp = cc2_rp_en ? 3'h0 : 3'h7;
endmodule : pbmc_partner

// >>> verification/test_pbmc_top.sv
// Self-checking bench of the power bank mode controller
`timescale 1ns/1ps
module test_pbmc_top;
  import pbmc_pkg::*;
  logic clk_sys, rst_n, ce, bat_present, bat_low, bat_above_3v, bat_near_target;
  logic bat_below_recharge, ichg_below_stop, vin_present, vin_fast, vin_droop, key_press;
  logic load_detect, boost_ocp, boost_short, boost_ovp, die_otp, die_hot, snk_att;
  logic chg_en, pin_limit_18w, out_port_en, boost_en, boost_soft, boost_derate, led_flash;
  logic cc1_rp_en, cc1_rd_en, cc2_rp_en, cc2_rd_en, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  cc1_cmp, cc2_cmp, ichg_code;
  logic [1:0]  boost_vsel, rp_level, snk_adv, s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, v;
  logic [3:0]  s_axi_wstrb;
  logic [12:0] bat_mv;
  int          fails, check_count, n;
  pbmc_top #(.DEB_CYCLES(4), .DRP_CYCLES(200), .DRP_SRC_CYCLES(100), .TRY_CYCLES(150),
    .LIGHT_CYCLES(300), .FLASH_CYCLES(5), .SOFT_CYCLES(10)) dut (.*);
  pbmc_partner u_partner (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task final_report;
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wt(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : wt
  task wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= dat;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_bvalid) break;
      aw = aw & ~s_axi_awready;
      w = w & ~s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd
  task flashes(output int cnt);
    logic prev;
    cnt = 0;
    prev = 1'b0;
    repeat (100)
    begin
      @(posedge clk_sys);
      if (led_flash && !prev) cnt++;
      prev = led_flash;
    end
  endtask : flashes
  // Level 3 is clamped to the 3.0 A advertisement
  function automatic logic [1:0] exp_rp(input logic [1:0] f);
    return (f == 2'h3) ? 2'h2 : f;
  endfunction : exp_rp
  initial
  begin
    {ce, bat_present, s_axi_wstrb} = 6'h3f;
    {rst_n, bat_low, vin_present, vin_fast, vin_droop, key_press, load_detect} = '0;
    {boost_ocp, boost_short, boost_ovp, die_otp, die_hot, snk_att, ichg_below_stop} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, bat_mv} = '0;
    v = $urandom(33);
    wt(16);
    rst_n <= 1'b1;
    flashes(n);
    chk("power-up flashes", n, 4);
    rd(ADDR_STATUS, d, r);
    chk("lock state", d[3:0], 4'h1);
    rd(ADDR_CTRL, d, r);
    chk("ctrl reset", d, 32'h0);
    load_detect <= 1'b1;
    key_press <= 1'b1;
    wt(8);
    key_press <= 1'b0;
    flashes(n);
    chk("lock key flashes", n, 4);
    chk("lock boost", boost_en, 1'b0);
    bat_mv <= 13'h0af0;
    vin_present <= 1'b1;
    wt(30);
    chk("charge on", chg_en, 1'b1);
    chk("trickle code", ichg_code, ICHG_TRICKLE);
    chk("ports closed", out_port_en, 1'b0);
    bat_mv <= 13'h0e74;
    wt(30);
    rd(ADDR_STATUS, d, r);
    chk("cc stage", d[7:4], 4'h2);
    chk("cc current", ichg_code, ICHG_MAX);
    vin_droop <= 1'b1;
    wt(30);
    vin_droop <= 1'b0;
    chk("droop step", ichg_code, ICHG_MAX - 3'h1);
    bat_mv <= 13'h1068;
    wt(30);
    rd(ADDR_STATUS, d, r);
    chk("cv stage", d[7:4], 4'h4);
    ichg_below_stop <= 1'b1;
    wt(30);
    chk("terminated", chg_en, 1'b0);
    bat_mv <= 13'h0fd2;
    wt(30);
    chk("recharge", chg_en, 1'b1);
    vin_fast <= 1'b1;
    wt(30);
    chk("18w limit", pin_limit_18w, 1'b1);
    {vin_fast, vin_present, ichg_below_stop} <= 3'h0;
    wt(30);
    chk("ports open", out_port_en, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      v = $urandom;
      wr(ADDR_CTRL, v, r);
      rd(ADDR_CTRL, d, r);
      chk("ctrl readback", d[3:0], v[3:0]);
      chk("boost level", boost_vsel, v[1:0]);
      chk("rp level", rp_level, exp_rp(v[3:2]));
    end
    die_hot <= 1'b1;
    wt(30);
    chk("derate", boost_derate, 1'b1);
    die_hot <= 1'b0;
    {boost_ocp, boost_short, boost_ovp, die_otp} <= {1'b1, 3'($urandom)};
    wt(30);
    chk("fault stop", boost_en, 1'b0);
    {boost_ocp, boost_short, boost_ovp, die_otp, snk_att} <= 5'h1;
    wt(600);
    rd(ADDR_CC, d, r);
    chk("source attach", d[3:0], 4'h4);
    chk("rp on cc1", cc1_rp_en, 1'b1);
    chk("other terms", {cc1_rd_en, cc2_rd_en, cc2_rp_en}, 3'h1);
    chk("sink adv", d[5:4], ADV_DEF);
    rd(8'h40, d, r);
    chk("unmapped read", r, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h0, r);
    chk("read-only write", r, RESP_SLVERR);
    {load_detect, bat_low} <= 2'h1;
    wt(30);
    rd(ADDR_STATUS, d, r);
    chk("low battery lock", d[3:0], 4'h1);
    final_report();
  end
  initial
  begin
    wt(20000);
    fails++;
    final_report();
  end
endmodule : test_pbmc_top
bind pbmc_top pbmc_props #(.DEB_CYCLES(DEB_CYCLES), .DRP_CYCLES(DRP_CYCLES)) u_props (.*);
